// File: osc_consts.svh
// constants for the sequencing output stage configuration block
// Notes on behaviour
// - polarity bit per output, 1 active-high
// - 3-bit stage decode for outputs 1-4
// - stage field positions per output group
// - 4-bit stage decode for outputs 5-8
// - reduced variant: input 5/6 codes unused
// - 3-bit timeout field selects eight periods
// - open-drain or weak pullup on every output
// - charge pump only on outputs 1-4, only 1-2 in the reduced variant
// - push-pull only on 5-8, input referenced
// - each output asserts only from its own enabled dependency source bit
// - reset: all zero, polarity all ones
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH
`define OSC_ADDR_OUT1    8'h11
`define OSC_ADDR_OUT2    8'h15
`define OSC_ADDR_OUT3    8'h1C
`define OSC_ADDR_OUT4    8'h23
`define OSC_ADDR_OUT5    8'h2A
`define OSC_ADDR_OUT6    8'h31
`define OSC_ADDR_OUT7    8'h35
`define OSC_ADDR_OUT8    8'h39
`define OSC_ADDR_POL     8'h3A
`define OSC_RST_CFG      8'h00
`define OSC_RST_POL      8'hFF
`define OSC_STG12_HI     6
`define OSC_STG12_LO     4
`define OSC_STG34_HI     7
`define OSC_STG34_LO     5
`define OSC_STG58_HI     7
`define OSC_STG58_LO     4
`define OSC_TMO_HI       3
`define OSC_TMO_LO       1
`define OSC_TMO34_HI     4
`define OSC_TMO34_LO     2
`define OSC_CLK_HZ       25000000
`define OSC_TICK_US      25
`define OSC_TICK_CYC     ((`OSC_CLK_HZ / 1000000) * `OSC_TICK_US)
`define OSC_T0_TICKS     1
`define OSC_T1_TICKS     62
`define OSC_T2_TICKS     250
`define OSC_T3_TICKS     1000
`define OSC_T4_TICKS     2000
`define OSC_T5_TICKS     8000
`define OSC_T6_TICKS     16000
`define OSC_T7_TICKS     64000
`endif

// File: osc_pkg.sv
// types for the sequencing output stage configuration block
package osc_pkg;
	typedef enum logic [3:0] {
		OSC_STG_OPEN_DRAIN,
		OSC_STG_PULLUP_IN3,
		OSC_STG_PULLUP_IN4,
		OSC_STG_PULLUP_IN5,
		OSC_STG_PULLUP_IN6,
		OSC_STG_PULLUP_RAIL,
		OSC_STG_CHARGE_PUMP,
		OSC_STG_PUSHPULL_IN3,
		OSC_STG_PUSHPULL_IN4,
		OSC_STG_PUSHPULL_IN5,
		OSC_STG_PUSHPULL_IN6,
		OSC_STG_UNUSED
	} osc_stage_t;
	typedef struct packed {
		logic       write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} osc_req_t;
	typedef struct packed {
		logic [7:0][7:0] cfg;
		logic [7:0]      pol;
		logic [7:0]      pre;
		logic [7:0][16:0] cnt;
		logic [9:0]      tick_div;
		logic [7:0]      rdata;
		logic            hit;
	} osc_state_t;
endpackage

// File: osc_output_stage_config.sv
// register file, stage decode and deassertion timers for the sequencing outputs
`timescale 1ns/1ps
`default_nettype none
`include "osc_consts.svh"
module osc_output_stage_config #(
	parameter bit          REDUCED  = 1'b0,
	parameter int unsigned TICK_CYC = `OSC_TICK_CYC
) (
	input  wire logic             clk_sys_i,
	input  wire logic             resetn_i,
	input  wire osc_pkg::osc_req_t req_i,
	output logic [7:0]            rdata_o,
	output logic                  hit_o,
	input  wire logic [7:0]       cond_src_i,
	input  wire logic [7:0]       dep_en_i,
	output logic [7:0]            seq_out_o,
	output logic [7:0]            seq_out_oe_o,
	output logic [7:0]            seq_asserted_o,
	output osc_pkg::osc_stage_t [7:0] stage_o
);
	import osc_pkg::*;

	osc_state_t st_r;
	osc_state_t st_nxt;
	logic [7:0] src_meta_r;
	logic [7:0] src_sync_r;

	function automatic logic [7:0] osc_addr(input int i);
		case (i)
			0: osc_addr = `OSC_ADDR_OUT1;
			1: osc_addr = `OSC_ADDR_OUT2;
			2: osc_addr = `OSC_ADDR_OUT3;
			3: osc_addr = `OSC_ADDR_OUT4;
			4: osc_addr = `OSC_ADDR_OUT5;
			5: osc_addr = `OSC_ADDR_OUT6;
			6: osc_addr = `OSC_ADDR_OUT7;
			default: osc_addr = `OSC_ADDR_OUT8;
		endcase
	endfunction

	function automatic logic [2:0] osc_tmo_field(input int i, input logic [7:0] r);
		if (i == 2 || i == 3)
			osc_tmo_field = r[`OSC_TMO34_HI:`OSC_TMO34_LO];
		else
			osc_tmo_field = r[`OSC_TMO_HI:`OSC_TMO_LO];
	endfunction

	function automatic logic [16:0] osc_tmo_ticks(input logic [2:0] c);
		case (c)
			3'h0: osc_tmo_ticks = 17'(`OSC_T0_TICKS);
			3'h1: osc_tmo_ticks = 17'(`OSC_T1_TICKS);
			3'h2: osc_tmo_ticks = 17'(`OSC_T2_TICKS);
			3'h3: osc_tmo_ticks = 17'(`OSC_T3_TICKS);
			3'h4: osc_tmo_ticks = 17'(`OSC_T4_TICKS);
			3'h5: osc_tmo_ticks = 17'(`OSC_T5_TICKS);
			3'h6: osc_tmo_ticks = 17'(`OSC_T6_TICKS);
			default: osc_tmo_ticks = 17'(`OSC_T7_TICKS);
		endcase
	endfunction

	// stage decode, unsupported codes fall to unused
	function automatic osc_stage_t osc_stage(input int i, input logic [7:0] r, input bit red);
		logic [3:0] c;
		c = 4'h0;
		osc_stage = OSC_STG_UNUSED;
		if (i < 2)
			c = {1'b0, r[`OSC_STG12_HI:`OSC_STG12_LO]};
		else if (i < 4)
			c = {1'b0, r[`OSC_STG34_HI:`OSC_STG34_LO]};
		else
			c = r[`OSC_STG58_HI:`OSC_STG58_LO];
		if (i < 4)
		begin
			case (c)
				4'h0: osc_stage = OSC_STG_OPEN_DRAIN;
				4'h1: osc_stage = OSC_STG_PULLUP_IN3;
				4'h2: osc_stage = OSC_STG_PULLUP_IN4;
				4'h3: osc_stage = OSC_STG_PULLUP_IN5;
				4'h4: osc_stage = OSC_STG_PULLUP_IN6;
				4'h5: osc_stage = OSC_STG_PULLUP_RAIL;
				4'h6: osc_stage = OSC_STG_CHARGE_PUMP;
				default: osc_stage = OSC_STG_UNUSED;
			endcase
		end
		else
		begin
			case (c)
				4'h0: osc_stage = OSC_STG_OPEN_DRAIN;
				4'h1: osc_stage = OSC_STG_PULLUP_IN3;
				4'h2: osc_stage = OSC_STG_PULLUP_IN4;
				4'h3: osc_stage = OSC_STG_PULLUP_IN5;
				4'h4: osc_stage = OSC_STG_PULLUP_IN6;
				4'h5: osc_stage = OSC_STG_PULLUP_RAIL;
				4'h6: osc_stage = OSC_STG_PUSHPULL_IN3;
				4'h7: osc_stage = OSC_STG_PUSHPULL_IN4;
				4'h8: osc_stage = OSC_STG_PUSHPULL_IN5;
				4'h9: osc_stage = OSC_STG_PUSHPULL_IN6;
				default: osc_stage = OSC_STG_UNUSED;
			endcase
		end
		if (red && (osc_stage == OSC_STG_PULLUP_IN5 || osc_stage == OSC_STG_PULLUP_IN6
			|| osc_stage == OSC_STG_PUSHPULL_IN5 || osc_stage == OSC_STG_PUSHPULL_IN6))
			osc_stage = OSC_STG_UNUSED;
		if (osc_stage == OSC_STG_CHARGE_PUMP && red && i > 1)
			osc_stage = OSC_STG_UNUSED;
	endfunction

	// dependency sources are asynchronous to this clock
	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			src_meta_r <= 8'h00;
			src_sync_r <= 8'h00;
		end
		else
		begin
			src_meta_r <= cond_src_i;
			src_sync_r <= src_meta_r;
		end
	end

	always_comb
	begin
		logic tick;
		logic cond;
		osc_stage_t s;
		tick = 1'b0;
		cond = 1'b0;
		s = OSC_STG_UNUSED;
		st_nxt = st_r;
		st_nxt.hit = 1'b0;
		st_nxt.rdata = 8'h00;
		tick = (st_r.tick_div == 10'(TICK_CYC - 1));
		st_nxt.tick_div = tick ? 10'h000 : st_r.tick_div + 10'h001;
		if (req_i.addr == `OSC_ADDR_POL)
		begin
			st_nxt.hit = 1'b1;
			st_nxt.rdata = st_r.pol;
			if (req_i.write)
				st_nxt.pol = req_i.wdata;
		end
		for (int i = 0; i < 8; i++)
		begin
			if (req_i.addr == osc_addr(i))
			begin
				st_nxt.hit = 1'b1;
				st_nxt.rdata = st_r.cfg[i];
				if (req_i.write)
					st_nxt.cfg[i] = req_i.wdata;
			end
			cond = |(src_sync_r & dep_en_i) && dep_en_i[i] && src_sync_r[i];
			st_nxt.pre[i] = cond;
			if (cond)
				st_nxt.cnt[i] = osc_tmo_ticks(osc_tmo_field(i, st_r.cfg[i]));
			else if (tick && st_r.cnt[i] != 17'h00000)
				st_nxt.cnt[i] = st_r.cnt[i] - 17'h00001;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			st_r <= '0;
			for (int i = 0; i < 8; i++)
				st_r.cfg[i] <= `OSC_RST_CFG;
			st_r.pol <= `OSC_RST_POL;
		end
		else
			st_r <= st_nxt;
	end

	always_comb
	begin
		logic act;
		osc_stage_t s;
		act = 1'b0;
		s = OSC_STG_UNUSED;
		rdata_o = st_r.rdata;
		hit_o = st_r.hit;
		for (int i = 0; i < 8; i++)
		begin
			s = osc_stage(i, st_r.cfg[i], REDUCED);
			if (i >= 4 && s == OSC_STG_CHARGE_PUMP)
				s = OSC_STG_UNUSED;
			if (i < 4 && (s >= OSC_STG_PUSHPULL_IN3 && s <= OSC_STG_PUSHPULL_IN6))
				s = OSC_STG_UNUSED;
			stage_o[i] = s;
			act = st_r.pre[i] || (st_r.cnt[i] != 17'h00000);
			seq_asserted_o[i] = act;
			seq_out_o[i] = st_r.pol[i] ? act : ~act;
			// open-drain and pullup drive low only
			if (s == OSC_STG_UNUSED)
				seq_out_oe_o[i] = 1'b0;
			else if (s >= OSC_STG_PUSHPULL_IN3 || s == OSC_STG_CHARGE_PUMP)
				seq_out_oe_o[i] = 1'b1;
			else
				seq_out_oe_o[i] = ~seq_out_o[i];
		end
	end
endmodule
`default_nettype wire

// File: osc_load.sv
// external pull-up load seen by each sequencing output pin
`timescale 1ns/1ps
`default_nettype none
module osc_load (
	input  wire logic [7:0] seq_out_i,
	input  wire logic [7:0] oe_i,
	output logic      [7:0] pin_o
);
	assign pin_o = (seq_out_i & oe_i) | ~oe_i;
endmodule
`default_nettype wire

// File: osc_props.sv
// port checks for the output stage configuration block
`timescale 1ns/1ps
`default_nettype none
module osc_props (
	input wire logic                      clk_sys_i,
	input wire logic                      resetn_i,
	input wire osc_pkg::osc_req_t         req_i,
	input wire logic [7:0]                rdata_o,
	input wire logic                      hit_o,
	input wire logic [7:0]                cond_src_i,
	input wire logic [7:0]                dep_en_i,
	input wire logic [7:0]                seq_out_o,
	input wire logic [7:0]                seq_out_oe_o,
	input wire logic [7:0]                seq_asserted_o,
	input wire osc_pkg::osc_stage_t [7:0] stage_o
);
	import osc_pkg::*;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	logic map;
	assign map = req_i.addr inside {8'h11, 8'h15, 8'h1C, 8'h23, 8'h2A, 8'h31, 8'h35, 8'h39, 8'h3A};
	AST_HIT: assert property (map |=> hit_o) else $error("mapped access unanswered");
	AST_MISS: assert property (!map |=> !hit_o && rdata_o == 8'h00) else $error("unmapped hit");
	for (genvar i = 0; i < 8; i++)
	begin : g_out
		AST_DRV: assert property (stage_o[i] inside {[OSC_STG_CHARGE_PUMP:OSC_STG_PUSHPULL_IN6]}
			|-> seq_out_oe_o[i]) else $error("driven stage off");
		AST_OFF: assert property (stage_o[i] == OSC_STG_UNUSED |-> !seq_out_oe_o[i]) else $error("unused drives");
		AST_PULL: assert property (stage_o[i] < OSC_STG_CHARGE_PUMP
			|-> seq_out_oe_o[i] == !seq_out_o[i]) else $error("pull stage drive");
		AST_UP: assert property (dep_en_i[i] && cond_src_i[i] [*4] |-> seq_asserted_o[i])
			else $error("no assertion");
		AST_HOLD: assert property ($fell(seq_asserted_o[i]) |-> !$past(dep_en_i[i] && cond_src_i[i]))
			else $error("early release");
		if (i > 3)
		begin : g_hi
			AST_NO_CP: assert property (stage_o[i] != OSC_STG_CHARGE_PUMP) else $error("pump on 5-8");
		end
		else
		begin : g_lo
			AST_NO_PP: assert property (!(stage_o[i] inside {[OSC_STG_PUSHPULL_IN3:OSC_STG_PUSHPULL_IN6]}))
				else $error("push-pull on 1-4");
		end
	end
	cover property (hit_o);
	cover property ($fell(seq_asserted_o[0]));
	cover property (stage_o[0] == OSC_STG_CHARGE_PUMP);
endmodule
bind osc_output_stage_config osc_props i_osc_props (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
	.req_i(req_i), .rdata_o(rdata_o), .hit_o(hit_o), .cond_src_i(cond_src_i), .dep_en_i(dep_en_i),
	.seq_out_o(seq_out_o), .seq_out_oe_o(seq_out_oe_o), .seq_asserted_o(seq_asserted_o),
	.stage_o(stage_o));
`default_nettype wire

// File: testbench.sv
// self-checking bench for the output stage configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import osc_pkg::*;
	logic             clk_sys_i;
	logic             resetn_i;
	osc_req_t         req_i;
	logic [7:0]       cond_src_i, dep_en_i, rdata_o, seq_out_o, seq_out_oe_o, seq_asserted_o, pin;
	logic             hit_o;
	osc_stage_t [7:0] stage_o;
	logic [8:0]       q [$];
	logic [8:0]       nt;
	logic [31:0]      r = 32'h224C512C;
	logic [7:0]       adr [9] = '{8'h11, 8'h15, 8'h1C, 8'h23, 8'h2A, 8'h31, 8'h35, 8'h39, 8'h3A};
	logic [7:0]       e;
	int               error_cnt, num_checks, n;
	int               tk [3] = '{1, 62, 250};
	// short tick keeps the tested timeouts (codes 0-2, up to 250 ticks) inside the 2000-cycle limit
	osc_output_stage_config #(.TICK_CYC(2)) i_osc_output_stage_config (.clk_sys_i(clk_sys_i),
		.resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o), .hit_o(hit_o),
		.cond_src_i(cond_src_i), .dep_en_i(dep_en_i), .seq_out_o(seq_out_o),
		.seq_out_oe_o(seq_out_oe_o), .seq_asserted_o(seq_asserted_o), .stage_o(stage_o));
	osc_load i_osc_load (.seq_out_i(seq_out_o), .oe_i(seq_out_oe_o), .pin_o(pin));
	always #20 clk_sys_i = ~clk_sys_i;
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction
	function automatic logic [7:0] fld(input int i, input int c);
		return i < 4 ? 8'((c & 7) << (i < 2 ? 4 : 5)) : 8'(c << 4);
	endfunction
	function automatic logic [7:0] stg(input int i, input int c);
		int m;
		m = i < 4 ? c & 7 : c;
		return 8'(m < 6 ? m : i < 4 ? (m == 6 ? 6 : 11) : (m < 10 ? m + 1 : 11));
	endfunction
	task automatic chk(input string s, input logic [7:0] ex, input logic [7:0] got);
		num_checks++;
		if (got !== ex)
		begin
			error_cnt++;
			$display("FAIL %s expected %h seen %h", s, ex, got);
		end
	endtask
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input int k,
		input logic [7:0] ex);
		req_i <= '{w, a, d};
		if (k > 0)
			q.push_back({k == 2, ex});
		@(posedge clk_sys_i);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk_sys_i)
		if (hit_o === 1'b1)
		begin
			if (q.size() == 0)
				chk("hit", 8'h00, 8'h01);
			else
			begin
				nt = q.pop_front();
				if (nt[8])
					chk("rdata", nt[7:0], rdata_o);
			end
		end
	initial
	begin
		clk_sys_i = 1'b0;
		resetn_i = 1'b0;
		req_i = '0;
		cond_src_i = 8'h00;
		dep_en_i = 8'h00;
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 9; i++) acc(0, adr[i], 0, 2, i == 8 ? 8'hFF : 8'h00);
		acc(0, 8'h12, 0, 0, 0);
		// every code, ending on open drain
		for (int c = 15; c >= 0; c--)
		begin
			for (int i = 0; i < 8; i++) acc(1, adr[i], fld(i, c), 1, 0);
			for (int i = 0; i < 8; i++)
			begin
				acc(0, adr[i], 0, 2, fld(i, c));
				chk("stage", stg(i, c), 8'(stage_o[i]));
			end
		end
		repeat (4)
		begin
			r = lfsr(r);
			acc(1, 8'h3A, r[7:0], 1, 0);
			acc(0, 8'h00, 0, 0, 0);
			dep_en_i <= r[15:8];
			cond_src_i <= r[23:16];
			repeat (10) @(posedge clk_sys_i);
			e = r[15:8] & r[23:16];
			chk("asserted", e, seq_asserted_o);
			chk("pin", ~(e ^ r[7:0]), pin);
		end
		for (int k = 0; k < 3; k++)
		begin
			acc(1, adr[k * 2], 8'(k << (k == 1 ? 2 : 1)), 1, 0);
			acc(0, 8'h00, 0, 0, 0);
			dep_en_i <= 8'hFF;
			cond_src_i <= 8'hFF;
			repeat (6) @(posedge clk_sys_i);
			cond_src_i <= 8'h00;
			n = 0;
			while (seq_asserted_o[k * 2] === 1'b1 && n < 2000)
			begin
				@(posedge clk_sys_i);
				n++;
			end
			chk("hold", 8'h01, 8'(n >= 2 * tk[k] && n <= 2 * tk[k] + 6));
			if (n == 2000)
				wrap_up();
		end
		wrap_up();
	end
endmodule
`default_nettype wire
